//--- rtl/iopd_pkg.sv
/*
 * Shared definitions for the per-port process-data block: register map,
 * field layout, reset values, mode enumerations and the carriers that
 * move process data and parameter-storage commands.
 * Assumes a single 50 MHz clock domain and a 32-bit register port.
 */
package iopd_pkg;
	// Process-data window and parameter-set widths
	localparam int PD_BYTES = 32;
	localparam int SIZE_W = 6;
	localparam int CKSUM_W = 16;
	localparam int PARAM_W = 32;
	localparam int REG_AW = 8;

	// Register byte offsets
	localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] OFS_SIZE = 8'h04;
	localparam logic [REG_AW-1:0] OFS_VENDOR = 8'h08;
	localparam logic [REG_AW-1:0] OFS_DEVICE = 8'h0c;
	localparam logic [REG_AW-1:0] OFS_STATUS = 8'h10;

	// Field positions
	localparam int CTRL_PORT_LSB = 0;
	localparam int CTRL_VAL_LSB = 3;
	localparam int CTRL_FS_LSB = 6;
	localparam int CTRL_SWAP_LSB = 8;
	localparam int SIZE_MAP_LSB = 0;
	localparam int SIZE_DEV_LSB = 8;
	localparam int STAT_PRESENT = 0;
	localparam int STAT_ACTIVE = 1;
	localparam int STAT_ACT_LSB = 2;
	localparam int STAT_CKSUM_LSB = 16;

	// Reset values
	localparam logic [SIZE_W-1:0] RST_SIZE = 6'h20;
	localparam logic [15:0] RST_VENDOR = 16'h0001;
	localparam logic [23:0] RST_DEVICE = 24'h000001;

	typedef enum logic [2:0] {
		PM_DEACTIVATED, PM_MANUAL, PM_AUTOSTART, PM_DIGITAL_IN, PM_DIGITAL_OUT
	} iopd_port_e;
	typedef enum logic [2:0] {
		VAL_NO_CHECK, VAL_V10, VAL_V11, VAL_V11_BKRES, VAL_V11_RESTORE
	} iopd_valid_e;
	typedef enum logic [1:0] {
		FS_ZERO_VALID, FS_HOLD, FS_ZERO_INVALID
	} iopd_fs_e;
	typedef enum logic [1:0] {SW_DIRECT, SW_16, SW_32, SW_ALL} iopd_swap_e;
	typedef enum logic [1:0] {ACT_NONE, ACT_CLEAR, ACT_BACKUP, ACT_RESTORE} iopd_act_e;

	typedef logic [PD_BYTES-1:0][7:0] iopd_bytes_t;

	// Process data with its validity qualifier
	typedef struct packed {
		logic valid;
		iopd_bytes_t data;
	} iopd_pd_s;

	// One storage command toward the device-side engine
	typedef struct packed {
		logic strobe;
		iopd_act_e act;
		logic [PARAM_W-1:0] param;
	} iopd_ds_cmd_s;
endpackage : iopd_pkg

//--- rtl/iopd_port.sv
/*
 * Per-port process-data handling of a fieldbus-attached link master:
 * fail-safe output selection, byte rearrangement between device data size
 * and mapping size, and the parameter-storage decision at link start-up.
 * Assumes all inputs synchronous to clk_i and a register master that
 * never issues read and write strobes together.
 */
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
module iopd_port (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [iopd_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic fb_fault_i,
	input wire iopd_pkg::iopd_pd_s fb_pd_i,
	output iopd_pkg::iopd_pd_s fb_pd_o,
	input wire iopd_pkg::iopd_pd_s dev_pd_i,
	output iopd_pkg::iopd_pd_s dev_pd_o,
	input wire logic link_start_i,
	input wire logic dev_bkup_req_i,
	input wire logic [iopd_pkg::CKSUM_W-1:0] dev_cksum_i,
	input wire logic [iopd_pkg::PARAM_W-1:0] dev_param_i,
	output iopd_pkg::iopd_ds_cmd_s ds_cmd_o,
	output logic ds_active_o
);
	import iopd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Byte rearrangement shared by both data directions
	function automatic iopd_bytes_t iopd_swap(
		input iopd_bytes_t d,
		input iopd_swap_e mode,
		input logic [SIZE_W-1:0] map_sz,
		input logic [SIZE_W-1:0] dev_sz
	);
		iopd_bytes_t pad;
		iopd_bytes_t res;
		int j;
		pad = '0;
		res = '0;
		j = 0;
		// Zero-fill past the device size before any swap
		for (int i = 0; i < PD_BYTES; i++) begin
			if (i < int'(dev_sz) && i < int'(map_sz)) begin
				pad[i] = d[i];
			end
		end
		for (int i = 0; i < PD_BYTES; i++) begin
			case (mode)
				SW_16: j = i ^ 1;
				SW_32: j = (map_sz == 6'h02) ? i : (i ^ 3);
				SW_ALL: j = int'(map_sz) - 1 - i;
				default: j = i;
			endcase
			// Sources outside the window read as padding
			if (i < int'(map_sz) && j >= 0 && j < PD_BYTES) begin
				res[i] = pad[j];
			end
		end
		return res;
	endfunction : iopd_swap

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	iopd_port_e port_q;
	iopd_valid_e val_q;
	iopd_fs_e fs_q;
	iopd_swap_e swap_q;
	logic [SIZE_W-1:0] map_q;
	logic [SIZE_W-1:0] dev_q;
	logic [15:0] vendor_q;
	logic [23:0] device_q;

	// Parameter storage state and the held output frame
	logic present_q;
	logic [CKSUM_W-1:0] cksum_q;
	logic [PARAM_W-1:0] param_q;
	iopd_act_e last_act_q;
	logic [PD_BYTES-1:0][7:0] last_out_q;

	logic wr_ctrl;
	logic wr_vendor;
	logic wr_device;
	logic id_change;
	logic leave_manual;
	logic store_on;
	iopd_port_e new_port;

	assign wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;
	assign wr_vendor = reg_wr_i && reg_addr_i == OFS_VENDOR;
	assign wr_device = reg_wr_i && reg_addr_i == OFS_DEVICE;
	assign new_port = iopd_port_e'(reg_wdata_i[CTRL_PORT_LSB +: 3]);
	// A rewrite with the same identifier keeps the stored set
	assign id_change = (wr_vendor && reg_wdata_i[15:0] != vendor_q) ||
		(wr_device && reg_wdata_i[23:0] != device_q);
	assign leave_manual = wr_ctrl && new_port != PM_MANUAL;
	assign store_on = port_q == PM_MANUAL &&
		(val_q == VAL_V11_BKRES || val_q == VAL_V11_RESTORE);

	// Control word; validation is forced back outside manual mode
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port_q <= PM_DEACTIVATED;
			val_q <= VAL_NO_CHECK;
			fs_q <= FS_ZERO_VALID;
			swap_q <= SW_DIRECT;
		end else if (wr_ctrl) begin
			port_q <= new_port;
			fs_q <= iopd_fs_e'(reg_wdata_i[CTRL_FS_LSB +: 2]);
			swap_q <= iopd_swap_e'(reg_wdata_i[CTRL_SWAP_LSB +: 2]);
			if (leave_manual) begin
				val_q <= VAL_NO_CHECK;
			end else begin
				val_q <= iopd_valid_e'(reg_wdata_i[CTRL_VAL_LSB +: 3]);
			end
		end
	end

	// Sizes and expected identifiers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			map_q <= RST_SIZE;
			dev_q <= RST_SIZE;
			vendor_q <= RST_VENDOR;
			device_q <= RST_DEVICE;
		end else begin
			if (reg_wr_i && reg_addr_i == OFS_SIZE) begin
				map_q <= reg_wdata_i[SIZE_MAP_LSB +: SIZE_W];
				dev_q <= reg_wdata_i[SIZE_DEV_LSB +: SIZE_W];
			end
			if (wr_vendor) begin
				vendor_q <= reg_wdata_i[15:0];
			end
			if (wr_device) begin
				device_q <= reg_wdata_i[23:0];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= '0;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= '0;
		end else if (reg_addr_i == OFS_CTRL) begin
			reg_rdata_o <= {22'h000000, swap_q, fs_q, val_q, port_q};
		end else if (reg_addr_i == OFS_SIZE) begin
			reg_rdata_o <= {18'h00000, dev_q, 2'h0, map_q};
		end else if (reg_addr_i == OFS_VENDOR) begin
			reg_rdata_o <= {16'h0000, vendor_q};
		end else if (reg_addr_i == OFS_DEVICE) begin
			reg_rdata_o <= {8'h00, device_q};
		end else if (reg_addr_i == OFS_STATUS) begin
			reg_rdata_o <= {cksum_q, 12'h000, last_act_q, ds_active_o, present_q};
		end else begin
			reg_rdata_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output direction: fieldbus to device, with fail-safe choice

	// Keep the last healthy upstream frame for the hold setting
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			last_out_q <= '0;
		end else if (!fb_fault_i && fb_pd_i.valid) begin
			last_out_q <= fb_pd_i.data;
		end
	end

	// Swap is applied after the fail-safe pick so held data follows setup
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dev_pd_o <= '0;
		end else if (!fb_fault_i) begin
			dev_pd_o.valid <= fb_pd_i.valid;
			dev_pd_o.data <= iopd_swap(fb_pd_i.data, swap_q, map_q, dev_q);
		end else begin
			case (fs_q)
				FS_HOLD: begin
					dev_pd_o.valid <= 1'b1;
					dev_pd_o.data <= iopd_swap(last_out_q, swap_q, map_q, dev_q);
				end
				FS_ZERO_INVALID: begin
					dev_pd_o.valid <= 1'b0;
					dev_pd_o.data <= '0;
				end
				default: begin
					dev_pd_o.valid <= 1'b1;
					dev_pd_o.data <= '0;
				end
			endcase
		end
	end

	// Input direction: device to fieldbus, same rearrangement
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fb_pd_o <= '0;
		end else begin
			fb_pd_o.valid <= dev_pd_i.valid;
			fb_pd_o.data <= iopd_swap(dev_pd_i.data, swap_q, map_q, dev_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parameter storage

	// Storage availability flag
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ds_active_o <= 1'b0;
		end else begin
			ds_active_o <= store_on;
		end
	end

	// Start-up decision; identity changes or leaving manual mode discard the set and win over a start-up in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			present_q <= 1'b0;
			cksum_q <= '0;
			param_q <= '0;
			last_act_q <= ACT_NONE;
			ds_cmd_o <= '0;
		end else begin
			ds_cmd_o.strobe <= 1'b0;
			if (id_change || leave_manual) begin
				present_q <= 1'b0;
				last_act_q <= ACT_CLEAR;
			end else if (link_start_i && !store_on) begin
				present_q <= 1'b0;
				last_act_q <= ACT_CLEAR;
				ds_cmd_o <= '{1'b1, ACT_CLEAR, '0};
			end else if (link_start_i && val_q == VAL_V11_BKRES) begin
				if (!present_q || (dev_bkup_req_i && cksum_q != dev_cksum_i)) begin
					present_q <= 1'b1;
					cksum_q <= dev_cksum_i;
					param_q <= dev_param_i;
					last_act_q <= ACT_BACKUP;
					ds_cmd_o <= '{1'b1, ACT_BACKUP, dev_param_i};
				end else if (!dev_bkup_req_i && cksum_q != dev_cksum_i) begin
					last_act_q <= ACT_RESTORE;
					ds_cmd_o <= '{1'b1, ACT_RESTORE, param_q};
				end else begin
					last_act_q <= ACT_NONE;
				end
			end else if (link_start_i) begin
				// Restore-only: backup requests are not looked at
				if (present_q && cksum_q != dev_cksum_i) begin
					last_act_q <= ACT_RESTORE;
					ds_cmd_o <= '{1'b1, ACT_RESTORE, param_q};
				end else begin
					last_act_q <= ACT_NONE;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	chk_zero_valid_out: assert property (
		fb_fault_i && fs_q == FS_ZERO_VALID |=>
			dev_pd_o.valid && dev_pd_o.data == '0)
		else $error("zero-valid fail-safe not applied");

	chk_hold_stable_out: assert property (
		(fb_fault_i && fs_q == FS_HOLD && !reg_wr_i)[*2] |=>
			dev_pd_o.valid && $stable(dev_pd_o.data))
		else $error("held output changed during fault");

	chk_zero_invalid_out: assert property (
		fb_fault_i && fs_q == FS_ZERO_INVALID |=>
			!dev_pd_o.valid && dev_pd_o.data == '0)
		else $error("zero-invalid fail-safe not applied");

	chk_swap16_pair: assert property (
		!fb_fault_i && swap_q == SW_16 && map_q == dev_q && map_q >= 6'h04 |=>
			dev_pd_o.data[0] == $past(fb_pd_i.data[1]) &&
			dev_pd_o.data[3] == $past(fb_pd_i.data[2]))
		else $error("16-bit swap wrong");

	chk_swap32_group: assert property (
		!fb_fault_i && swap_q == SW_32 && map_q == dev_q && map_q >= 6'h04 |=>
			dev_pd_o.data[0] == $past(fb_pd_i.data[3]) &&
			dev_pd_o.data[2] == $past(fb_pd_i.data[1]))
		else $error("32-bit swap wrong");

	chk_swap_all_ends: assert property (
		!fb_fault_i && swap_q == SW_ALL && map_q == 6'h08 && dev_q == 6'h08 |=>
			dev_pd_o.data[0] == $past(fb_pd_i.data[7]) &&
			dev_pd_o.data[7] == $past(fb_pd_i.data[0]))
		else $error("full swap wrong");

	chk_swap32_two_byte: assert property (
		!fb_fault_i && swap_q == SW_32 && map_q == 6'h02 && dev_q == 6'h02 |=>
			dev_pd_o.data[1:0] == $past(fb_pd_i.data[1:0]))
		else $error("two-byte map was rearranged");

	chk_pad_zero: assert property (
		!fb_fault_i && swap_q == SW_DIRECT && dev_q < map_q |=>
			dev_pd_o.data[$past(dev_q)] == 8'h00)
		else $error("padding byte not zero");

	chk_store_active: assert property (
		##1 ds_active_o == ($past(port_q) == PM_MANUAL &&
			($past(val_q) == VAL_V11_BKRES || $past(val_q) == VAL_V11_RESTORE)))
		else $error("storage active flag wrong");

	chk_start_clear: assert property (
		link_start_i && !id_change && !leave_manual && !store_on |=>
			ds_cmd_o.strobe && ds_cmd_o.act == ACT_CLEAR && !present_q)
		else $error("start-up clear missing");

	chk_backup_empty: assert property (
		link_start_i && store_on && val_q == VAL_V11_BKRES && !present_q &&
			!id_change && !leave_manual |=>
			ds_cmd_o.act == ACT_BACKUP && present_q &&
			cksum_q == $past(dev_cksum_i))
		else $error("backup into empty store missing");

	chk_restore_only: assert property (
		link_start_i && store_on && val_q == VAL_V11_RESTORE && present_q &&
			cksum_q != dev_cksum_i && !id_change && !leave_manual |=>
			ds_cmd_o.strobe && ds_cmd_o.act == ACT_RESTORE &&
			ds_cmd_o.param == param_q)
		else $error("restore-only did not restore");

	chk_id_discard: assert property (
		id_change |=> !present_q)
		else $error("identifier change kept stored set");

	chk_leave_manual: assert property (
		leave_manual |=> val_q == VAL_NO_CHECK && !present_q ##1 !ds_active_o)
		else $error("leaving manual mode not handled");
endmodule : iopd_port

//--- tb/iopd_dev_model.sv
/*
 * Behavioural device on the port: streams input data, keeps a parameter
 * set and adopts a restored set. Assumes the master's clock and reset.
 */
`timescale 1ns/100ps
module iopd_dev_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic load_i,
	input wire logic [iopd_pkg::PARAM_W-1:0] load_param_i,
	input wire iopd_pkg::iopd_bytes_t src_i,
	input wire iopd_pkg::iopd_ds_cmd_s ds_cmd_i,
	output iopd_pkg::iopd_pd_s dev_pd_o,
	output logic [iopd_pkg::CKSUM_W-1:0] cksum_o,
	output logic [iopd_pkg::PARAM_W-1:0] param_o
);
	import iopd_pkg::*;
	logic [PARAM_W-1:0] param_q;
	////////////////////////////////////////
	// Parameter set; a load stands for fitting a fresh device
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			param_q <= 32'h13579bdf;
		end else if (ds_cmd_i.strobe && ds_cmd_i.act == ACT_RESTORE) begin
			param_q <= ds_cmd_i.param;
		end else if (load_i) begin
			param_q <= load_param_i;
		end
	end
	// Checksum follows the set, so a restore makes both sides agree
	assign cksum_o = param_q[15:0] ^ param_q[31:16];
	assign param_o = param_q;
	assign dev_pd_o = {1'b1, src_i};
endmodule : iopd_dev_model

//--- tb/iolink_port_pd_swap_datastore_tb.sv
/*
 * Self-checking bench for the per-port process-data block.
 * Assumes the device model beside it and a 50 MHz clock.
 */
`timescale 1ns/100ps
module iolink_port_pd_swap_datastore_tb;
	import iopd_pkg::*;
	logic clk_i, nrst_i, reg_wr, reg_rd, fb_fault, link_start, bkup_req;
	logic load, ds_active;
	logic [REG_AW-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_q, stored, load_param, dev_param;
	logic [CKSUM_W-1:0] dev_cksum;
	iopd_pd_s fb_pd, fb_pd_o, dev_pd_i, dev_pd_o;
	iopd_bytes_t src;
	iopd_ds_cmd_s ds_cmd;
	logic [77:0] rows [9];
	int n_errors = 0;
	int checked = 0;
	////////////////////////////////////////
	iopd_port uut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .fb_fault_i(fb_fault), .fb_pd_i(fb_pd),
		.fb_pd_o(fb_pd_o), .dev_pd_i(dev_pd_i), .dev_pd_o(dev_pd_o),
		.link_start_i(link_start), .dev_bkup_req_i(bkup_req),
		.dev_cksum_i(dev_cksum), .dev_param_i(dev_param),
		.ds_cmd_o(ds_cmd), .ds_active_o(ds_active));
	iopd_dev_model dev (.clk_i(clk_i), .nrst_i(nrst_i), .load_i(load),
		.load_param_i(load_param), .src_i(src), .ds_cmd_i(ds_cmd),
		.dev_pd_o(dev_pd_i), .cksum_o(dev_cksum), .param_o(dev_param));
	// 20 ns clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	////////////////////////////////////////
	// Comparisons and bus cycles
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_pd(input string nm, input iopd_pd_s e, input iopd_pd_s g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_pd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1 rd_q = reg_rdata;
		chk($sformatf("reg %h", a), e, rd_q & m);
	endtask : rdc
	// Link start-up pulse; request level is sampled with it
	task automatic go(input logic rq);
		@(posedge clk_i);
		bkup_req <= rq;
		link_start <= 1'b1;
		@(posedge clk_i);
		link_start <= 1'b0;
		#1;
	endtask : go
	// Start-up under manual mode; np loads a fresh device set first
	task automatic ds(input logic [2:0] v, input logic rq,
		input logic [31:0] np, input logic es, input logic [1:0] ea);
		wr(OFS_CTRL, {26'h0, v, 3'h1});
		if (np !== 32'h0) begin
			@(posedge clk_i);
			load <= 1'b1;
			load_param <= np;
			@(posedge clk_i);
			load <= 1'b0;
		end
		go(rq);
		chk("strobe", {31'h0, es}, {31'h0, ds_cmd.strobe});
		chk("active", {31'h0, v > 3'h2}, {31'h0, ds_active});
		if (es) begin
			chk("act", {30'h0, ea}, {30'h0, ds_cmd.act});
			chk("param", ea == 2'h2 ? dev_param : stored, ds_cmd.param);
			if (ea == 2'h2) stored = dev_param;
		end
	endtask : ds
	task automatic results();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	////////////////////////////////////////
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		results();
	end
	// Rows: swap, map size, device size, expected bytes 7..0
	initial begin
		rows = '{{2'h0, 6'h8, 6'h8, 64'hefcdab8967452301},
			{2'h1, 6'h8, 6'h8, 64'hcdef89ab45670123},
			{2'h2, 6'h8, 6'h8, 64'h89abcdef01234567},
			{2'h3, 6'h8, 6'h8, 64'h0123456789abcdef},
			{2'h2, 6'h2, 6'h2, 64'h2301},
			{2'h0, 6'h8, 6'h5, 64'h8967452301},
			{2'h3, 6'h8, 6'h5, 64'h0123456789000000},
			{2'h2, 6'h8, 6'h5, 64'h8900000001234567},
			{2'h1, 6'h6, 6'h6, 64'h89ab45670123}};
		src = {{24{8'h5a}}, 64'hefcdab8967452301};
		{reg_wr, reg_rd, fb_fault, link_start, bkup_req, load} = 6'h0;
		{reg_addr, reg_wdata, load_param, stored} = '0;
		fb_pd = {1'b1, src};
		nrst_i = 1'b0;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (int r = 0; r < 9; r++) begin
			wr(OFS_SIZE, {18'h0, rows[r][69:64], 2'h0, rows[r][75:70]});
			wr(OFS_CTRL, {22'h0, rows[r][77:76], 8'h0});
			repeat (2) @(posedge clk_i);
			#1 chk_pd("to_dev", {1'b1, 256'(rows[r][63:0])}, dev_pd_o);
			chk_pd("to_fb", {1'b1, 256'(rows[r][63:0])}, fb_pd_o);
			$display("swap row %0d done", r);
		end
		// Fault after good data, for each fail-safe choice
		wr(OFS_SIZE, 32'h0808);
		for (int k = 0; k < 3; k++) begin
			wr(OFS_CTRL, {24'h0, k[1:0], 6'h0});
			fb_fault <= 1'b0;
			fb_pd <= {1'b1, src};
			repeat (2) @(posedge clk_i);
			fb_pd <= {1'b1, ~src};
			fb_fault <= 1'b1;
			repeat (2) @(posedge clk_i);
			#1 chk_pd("failsafe", {k != 2, k == 1 ? 256'(src[7:0]) : 256'h0}, dev_pd_o);
		end
		@(posedge clk_i);
		fb_fault <= 1'b0;
		$display("fail-safe test done");
		ds(3'h3, 1'b0, 32'h0, 1'b1, 2'h2);
		rdc(OFS_STATUS, 32'h8888000b, '1);
		ds(3'h3, 1'b0, 32'h00010002, 1'b1, 2'h3);
		ds(3'h3, 1'b0, 32'h0, 1'b0, 2'h0);
		ds(3'h3, 1'b1, 32'h0, 1'b0, 2'h0);
		ds(3'h3, 1'b1, 32'h0a0b0c0d, 1'b1, 2'h2);
		ds(3'h4, 1'b1, 32'h11112222, 1'b1, 2'h3);
		ds(3'h4, 1'b0, 32'h0, 1'b0, 2'h0);
		for (int i = 0; i < 2; i++) begin
			ds(3'h3, 1'b1, i ? 32'h0 : 32'h11112222, 1'b1, 2'h2);
			wr(i ? OFS_DEVICE : OFS_VENDOR, 32'h00ab);
			rdc(OFS_STATUS, 32'h6, 32'hf);
		end
		ds(3'h4, 1'b0, 32'h00010002, 1'b0, 2'h0);
		for (int v = 0; v < 3; v++) begin
			ds(3'h3, 1'b1, 32'h0, 1'b1, 2'h2);
			wr(OFS_CTRL, {26'h0, v[2:0], 3'h1});
			go(1'b1);
			chk("clear_cmd", 32'h5, {29'h0, ds_cmd.strobe, ds_cmd.act});
			rdc(OFS_STATUS, 32'h4, 32'hf);
		end
		ds(3'h3, 1'b1, 32'h0, 1'b1, 2'h2);
		wr(OFS_CTRL, 32'h1a);
		rdc(OFS_CTRL, 32'h2, 32'h3ff);
		rdc(OFS_STATUS, 32'h4, 32'hf);
		$display("storage test done");
		// Second reset in mid-run, then reset values and a hole
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk_pd("reset_pd", '0, dev_pd_o);
		nrst_i <= 1'b1;
		rdc(OFS_CTRL, 32'h0, '1);
		rdc(OFS_SIZE, 32'h2020, '1);
		rdc(OFS_VENDOR, 32'h1, '1);
		rdc(OFS_DEVICE, 32'h1, '1);
		rdc(OFS_STATUS, 32'h0, '1);
		rdc(8'h14, 32'h0, '1);
		$display("reset test done");
		results();
	end
endmodule : iolink_port_pd_swap_datastore_tb
